/* root_port_throttle_hotplug.sv */
// Root port link throttling, diagnostic I/O claim, hot-plug status and link mode bits
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "rpt_map.svh"

module root_port_throttle_hotplug #(
  parameter int LANES  = 4,
  parameter int ZT_W   = 8,
  parameter int TP_W   = 16,
  parameter int MULT_W = 4
) (
  input  wire logic                clk_sys,
  input  wire logic                reset,
  input  wire rpt_pkg::reg_req_t   reg_req,
  output logic [31:0]              reg_rdata,
  input  wire logic [3:0]          severity_level,
  input  wire logic                presence_detect,
  input  wire logic                link_active,
  input  wire rpt_pkg::link_state_t link_state,
  input  wire logic [LANES-1:0]    lane_rx_inverted,
  input  wire logic                sris_strap,
  input  wire rpt_pkg::io_req_t    io_req,
  output logic                     io_claim,
  output rpt_pkg::io_req_t         io_fwd,
  output logic                     block_tlp,
  output logic                     block_opp_fc,
  output logic                     freeze_credits,
  output logic                     intx_level,
  output logic                     msi_send,
  output logic                     hotplug_sci_status,
  output logic                     system_management_irq,
  output logic                     ptm_enable,
  output logic                     l0s_supported,
  output logic [2:0]               l1_exit_latency,
  output logic [LANES-1:0]         lane_invert
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [3:0]          sev_s1;
    logic [3:0]          sev_s2;
    logic [3:0]          sev_prev;
    logic                pres_s1;
    logic                pres_s2;
    logic                sris_s1;
    logic                sris_s2;
    logic                lnk_prev;
    logic [`CTRL_W-1:0]  ctrl;
    logic [ZT_W-1:0]     zt;
    logic [TP_W-1:0]     tp;
    logic [4*MULT_W-1:0] mult;
    logic                en_prev;
    logic                was_l1;
    logic [TP_W-1:0]     win;
    logic                blk;
    logic                pres_state;
    logic                pres_chg;
    logic                sci_st;
    logic                smi_pres;
    logic                smi_lnk;
    logic                smi;
    logic                icond;
    logic                intx;
    logic                msi;
    logic                claim;
    rpt_pkg::io_req_t    fwd;
    logic                l0s;
    logic [2:0]          l1lat;
    logic [LANES-1:0]    inv;
    logic [31:0]         rdata;
  } st_t;

  st_t q;
  st_t d;

  // ==========================================================
  // Helpers
  function automatic logic [1:0] top_level(input logic [3:0] s);
    logic [1:0] r;
    r = 2'h0;
    for (int i = 0; i < 4; i++)
    begin
      if (s[i])
      begin
        r = 2'(i);
      end
    end
    return r;
  endfunction

  function automatic logic is_addr(input rpt_pkg::reg_req_t r, input logic [7:0] a);
    return r.addr == a;
  endfunction

  logic [1:0]           lvl;
  logic [ZT_W+MULT_W-1:0] zl;
  logic                 restart;
  logic [`STAT_W-1:0]   clr;

  assign lvl = top_level(q.sev_s2);
  assign zl = q.zt * q.mult[lvl*MULT_W +: MULT_W];
  assign restart = (q.ctrl[`C_THR_EN] & ~q.en_prev) | (q.sev_s2 != q.sev_prev)
                 | (q.was_l1 & (link_state != rpt_pkg::LS_L1));
  assign clr = (reg_req.wr && is_addr(reg_req, `A_STAT)) ? reg_req.wdata[`STAT_W-1:0] : '0;

  // ==========================================================
  // Next state
  always_comb
  begin
    logic run;
    logic pres_evt;
    logic lnk_evt;
    logic hit;
    run = 1'b0;
    pres_evt = 1'b0;
    lnk_evt = 1'b0;
    hit = 1'b0;
    d = q;
    d.sev_s1 = severity_level;
    d.sev_s2 = q.sev_s1;
    d.sev_prev = q.sev_s2;
    d.pres_s1 = presence_detect;
    d.pres_s2 = q.pres_s1;
    d.sris_s1 = sris_strap;
    d.sris_s2 = q.sris_s1;
    d.lnk_prev = link_active;
    d.en_prev = q.ctrl[`C_THR_EN];
    d.was_l1 = (link_state == rpt_pkg::LS_L1);

    // Register writes
    if (reg_req.wr)
    begin
      if (is_addr(reg_req, `A_CTRL))
      begin
        d.ctrl = reg_req.wdata[`CTRL_W-1:0];
      end
      if (is_addr(reg_req, `A_TIME))
      begin
        d.zt = reg_req.wdata[`T_ZT_LSB +: ZT_W];
        d.tp = reg_req.wdata[`T_TP_LSB +: TP_W];
      end
      if (is_addr(reg_req, `A_MULT))
      begin
        d.mult = reg_req.wdata[4*MULT_W-1:0];
      end
    end

    unique case (link_state)
      rpt_pkg::LS_L0, rpt_pkg::LS_L0S, rpt_pkg::LS_TRAIN, rpt_pkg::LS_OTHER: run = 1'b1;
      rpt_pkg::LS_L1, rpt_pkg::LS_L23, rpt_pkg::LS_DOWN: run = 1'b0;
      default: run = 1'b0;
    endcase

    if (!q.ctrl[`C_THR_EN] || restart)
    begin
      d.win = '0;
    end
    else if (run)
    begin
      d.win = (32'(q.win) + 32'd1 >= 32'(q.tp)) ? '0 : q.win + TP_W'(1);
    end

    d.blk = q.ctrl[`C_THR_EN] & (|q.sev_s2) & (32'(d.win) < 32'(zl));

    pres_evt = q.pres_s2 != q.pres_state;
    lnk_evt = link_active != q.lnk_prev;
    d.pres_state = q.pres_s2;
    d.pres_chg = (q.pres_chg & ~clr[`S_PDC]) | pres_evt;
    d.sci_st = (q.sci_st & ~clr[`S_SCI])
             | (pres_evt & q.ctrl[`C_PDE] & q.ctrl[`C_SCI]);
    d.smi_pres = (q.smi_pres & ~clr[`S_SMIP]) | (pres_evt & q.ctrl[`C_SMI]);
    d.smi_lnk = (q.smi_lnk & ~clr[`S_SMIL]) | (lnk_evt & q.ctrl[`C_SMI]);
    d.smi = d.smi_pres | d.smi_lnk;
    d.icond = d.pres_chg & q.ctrl[`C_PDE] & q.ctrl[`C_HPE];
    d.intx = d.icond & ~q.ctrl[`C_MSI];
    d.msi = d.icond & q.ctrl[`C_MSI] & (~q.icond | pres_evt);

    hit = io_req.valid && q.ctrl[`C_PPDE] && io_req.addr >= `IO_LO && io_req.addr <= `IO_HI;
    d.claim = hit;
    d.fwd = io_req;
    d.fwd.valid = hit;

    d.l0s = ~q.sris_s2;
    d.l1lat = q.sris_s2 ? `L1_EXIT_SRIS : `L1_EXIT_NORM;

    for (int i = 0; i < LANES; i++)
    begin
      if (link_state == rpt_pkg::LS_DOWN)
      begin
        d.inv[i] = 1'b0;
      end
      else if (link_state == rpt_pkg::LS_TRAIN && lane_rx_inverted[i])
      begin
        d.inv[i] = 1'b1;
      end
    end

    // Register reads
    d.rdata = '0;
    if (reg_req.rd)
    begin
      if (is_addr(reg_req, `A_CTRL))
      begin
        d.rdata[`CTRL_W-1:0] = q.ctrl;
      end
      if (is_addr(reg_req, `A_TIME))
      begin
        d.rdata[`T_ZT_LSB +: ZT_W] = q.zt;
        d.rdata[`T_TP_LSB +: TP_W] = q.tp;
      end
      if (is_addr(reg_req, `A_MULT))
      begin
        d.rdata[4*MULT_W-1:0] = q.mult;
      end
      if (is_addr(reg_req, `A_STAT))
      begin
        d.rdata[`S_PDS] = q.pres_state;
        d.rdata[`S_PDC] = q.pres_chg;
        d.rdata[`S_SCI] = q.sci_st;
        d.rdata[`S_SMIP] = q.smi_pres;
        d.rdata[`S_SMIL] = q.smi_lnk;
        d.rdata[`S_THR] = q.blk;
        d.rdata[`S_LNK] = q.lnk_prev;
        d.rdata[`S_SRIS] = q.sris_s2;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata = q.rdata;
  assign io_claim = q.claim;
  assign io_fwd = q.fwd;
  assign block_tlp = q.blk;
  assign block_opp_fc = q.blk;
  assign freeze_credits = q.blk;
  assign intx_level = q.intx;
  assign msi_send = q.msi;
  assign hotplug_sci_status = q.sci_st;
  assign system_management_irq = q.smi;
  assign ptm_enable = q.ctrl[`C_PTM];
  assign l0s_supported = q.l0s;
  assign l1_exit_latency = q.l1lat;
  assign lane_invert = q.inv;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  property p_blk_cause;
    block_tlp |-> $past(q.ctrl[`C_THR_EN]) && $past(|q.sev_s2) && freeze_credits;
  endproperty
  a_blk_cause: assert property (p_blk_cause) else $error("block without cause");

  property p_zone_len;
    q.blk |-> 32'(q.win) < $past(32'(zl));
  endproperty
  a_zone_len: assert property (p_zone_len) else $error("block outside zone");

  property p_restart;
    q.ctrl[`C_THR_EN] && !q.en_prev |=> q.win == '0;
  endproperty
  a_restart: assert property (p_restart) else $error("window not restarted");

  property p_hold;
    q.ctrl[`C_THR_EN] && !restart
      && link_state inside {rpt_pkg::LS_L1, rpt_pkg::LS_L23, rpt_pkg::LS_DOWN}
      |=> $stable(q.win);
  endproperty
  a_hold: assert property (p_hold) else $error("timer ran while link idle");

  property p_off;
    !q.ctrl[`C_THR_EN] |=> !block_tlp && q.win == '0;
  endproperty
  a_off: assert property (p_off) else $error("throttle active while disabled");

  property p_claim;
    io_req.valid && q.ctrl[`C_PPDE] && io_req.addr == `IO_LO
      |=> io_claim && io_fwd.addr == $past(io_req.addr) && io_fwd.data == $past(io_req.data);
  endproperty
  a_claim: assert property (p_claim) else $error("diagnostic cycle not claimed");

  property p_sris;
    q.sris_s2 |=> !l0s_supported && l1_exit_latency == `L1_EXIT_SRIS;
  endproperty
  a_sris: assert property (p_sris) else $error("separate clock limits missing");

  property p_arrive;
    q.pres_s2 && !q.pres_state |=> q.pres_state && q.pres_chg;
  endproperty
  a_arrive: assert property (p_arrive) else $error("arrival not recorded");

  property p_remove;
    !q.pres_s2 && q.pres_state |=> !q.pres_state && q.pres_chg;
  endproperty
  a_remove: assert property (p_remove) else $error("removal not recorded");

  property p_smi;
    (q.smi_pres || q.smi_lnk) |-> system_management_irq;
  endproperty
  a_smi: assert property (p_smi) else $error("management interrupt missing");

  c_blk: cover property ($rose(block_tlp));
  c_claim: cover property (io_claim);
  c_smi: cover property ($rose(system_management_irq));
  c_msi: cover property (msi_send);

endmodule
`default_nettype wire

/* rpt_map.svh */
// Register map, field positions and timing figures of the throttle and hot-plug block
`ifndef RPT_MAP_SVH
`define RPT_MAP_SVH

// ==========================================================
// Register offsets
`define A_CTRL 8'h00
`define A_TIME 8'h04
`define A_MULT 8'h08
`define A_STAT 8'h0C

// ==========================================================
// Control register bits
`define C_THR_EN 0
`define C_PPDE 1
`define C_PDE 2
`define C_HPE 3
`define C_SCI 4
`define C_SMI 5
`define C_MSI 6
`define C_PTM 7
`define CTRL_W 8

// ==========================================================
// Status register bits
`define S_PDS 0
`define S_PDC 1
`define S_SCI 2
`define S_SMIP 3
`define S_SMIL 4
`define S_THR 5
`define S_LNK 6
`define S_SRIS 7
`define STAT_W 8

// ==========================================================
// Timing register fields
`define T_ZT_LSB 0
`define T_TP_LSB 16

// ==========================================================
// Decode range and link figures
`define IO_LO 16'h0080
`define IO_HI 16'h008F
`define L1_EXIT_SRIS 3'h4
`define L1_EXIT_NORM 3'h2
`define RESP_US 100
`define CLK_MHZ 50

`endif

/* rpt_pkg.sv */
// Types shared by the throttle and hot-plug block and its surroundings
`default_nettype none
package rpt_pkg;

  typedef enum logic [2:0] {
    LS_L0    = 3'b000,
    LS_L0S   = 3'b001,
    LS_L1    = 3'b010,
    LS_L23   = 3'b011,
    LS_DOWN  = 3'b100,
    LS_TRAIN = 3'b101,
    LS_OTHER = 3'b110
  } link_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [3:0]  be;
    logic [31:0] data;
  } io_req_t;

endpackage
`default_nettype wire

/* rpt_partner.sv */
// Downstream diagnostic device model answering forwarded I/O cycles
`timescale 1ns/100ps
`default_nettype none
module rpt_partner (
  input  wire logic             clk_sys,
  input  wire rpt_pkg::io_req_t io_fwd,
  output logic                  rsp_valid,
  output logic [31:0]           rsp_data
);
  logic [31:0] mem [16];
  initial rsp_valid = 1'b0;
  initial rsp_data = 32'h0000_0000;
  always @(posedge clk_sys)
  begin
    rsp_valid <= io_fwd.valid & ~io_fwd.write;
    // Idle data toggles every cycle
    rsp_data <= ~rsp_data;
    if (io_fwd.valid & io_fwd.write)
      mem[io_fwd.addr[3:0]] <= io_fwd.data;
    else if (io_fwd.valid)
      rsp_data <= mem[io_fwd.addr[3:0]];
  end
endmodule
`default_nettype wire

/* root_port_throttle_hotplug_bench.sv */
// Self-checking bench for the throttle and hot-plug block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, x, g) begin checked++; if ((x) !== (g)) begin fails++; \
  $display("unexpected %s exp %0h got %0h", nm, x, g); end end
module root_port_throttle_hotplug_bench;
  logic                 clk_sys, reset, pres, lact, sris, rd_pend, rv;
  logic                 claim, blk, bopp, frz, intx, msi, sci, smi, ptm, l0s;
  rpt_pkg::reg_req_t    reg_req;
  rpt_pkg::io_req_t     io_req, io_fwd;
  rpt_pkg::link_state_t lst;
  logic [31:0]          rdata, rd_dat, r, lw;
  logic [3:0]           sev, rxinv, linv;
  logic [2:0]           l1x;
  logic [48:0]          e;
  logic [48:0]          rq[$], iq[$], pq[$];
  logic [15:0]          ad [4] = '{16'h007F, 16'h0080, 16'h008F, 16'h0090};
  int                   fails, checked, cyc, n, mcnt;

  root_port_throttle_hotplug root_port_throttle_hotplug_inst (
    .clk_sys(clk_sys), .reset(reset), .reg_req(reg_req), .reg_rdata(rdata),
    .severity_level(sev), .presence_detect(pres), .link_active(lact),
    .link_state(lst), .lane_rx_inverted(rxinv), .sris_strap(sris), .io_req(io_req),
    .io_claim(claim), .io_fwd(io_fwd), .block_tlp(blk), .block_opp_fc(bopp),
    .freeze_credits(frz), .intx_level(intx), .msi_send(msi),
    .hotplug_sci_status(sci), .system_management_irq(smi), .ptm_enable(ptm),
    .l0s_supported(l0s), .l1_exit_latency(l1x), .lane_invert(linv));
  rpt_partner rpt_partner_inst (.clk_sys(clk_sys), .io_fwd(io_fwd), .rsp_valid(rv),
    .rsp_data(rd_dat));

  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // Monitor
  always @(posedge clk_sys) rd_pend <= reg_req.rd;
  always @(negedge clk_sys)
  begin
    if (rd_pend === 1'b1)
    begin
      e = rq.pop_front();
      `CHK("reg_rdata", e[31:0], rdata)
    end
    if (claim === 1'b1)
    begin
      e = iq.size() ? iq.pop_front() : 49'h0;
      `CHK("io_fwd", e, {io_fwd.valid, io_fwd.addr, io_fwd.data})
    end
    if (rv === 1'b1)
    begin
      e = pq.pop_front();
      `CHK("diag read", e[31:0], rd_dat)
    end
    if (msi === 1'b1) mcnt++;
    `CHK("credit block", {blk, blk}, {bopp, frz})
  end

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      final_report();
    end
  end

  // ==========================================================
  // Tasks
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_req <= '{wr: w, rd: ~w, addr: a, wdata: d};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    rq.push_back({17'h0, x});
    bus(1'b0, a, 32'h0000_0000);
    @(negedge clk_sys);
  endtask

  task automatic io(input logic w, input logic [15:0] a, input logic [31:0] d, input logic h);
    @(posedge clk_sys);
    io_req <= '{valid: 1'b1, write: w, addr: a, be: 4'hF, data: d};
    if (h) iq.push_back({1'b1, a, d});
    @(posedge clk_sys);
    io_req <= '0;
  endtask

  task automatic wt(input int c);
    repeat (c) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic span;
    n = 0;
    repeat (16)
    begin
      @(negedge clk_sys);
      n += (blk === 1'b0) ? 0 : 1;
    end
    @(posedge clk_sys);
  endtask

  task automatic final_report;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================
  // Tests
  initial
  begin
    reg_req = '0;
    io_req = '0;
    sev = 4'h0;
    pres = 1'b0;
    lact = 1'b0;
    sris = 1'b0;
    lst = rpt_pkg::LS_L0;
    rxinv = 4'h0;
    reset = 1'b1;
    r = $urandom(32'h7793);
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    rd(8'h00, 0);
    rd(8'h0C, 0);
    rd(8'h10, 0);
    r = $urandom();
    bus(1, 8'h04, r);
    rd(8'h04, r & 32'hFFFF_00FF);
    r = $urandom();
    bus(1, 8'h08, r);
    rd(8'h08, r & 32'h0000_FFFF);
    bus(1, 8'h00, 32'h0000_0080);
    wt(2);
    `CHK("ptm", 1'b1, ptm)
    `CHK("l1 exit", 4'hA, {l0s, l1x})
    $display("test registers done");
    bus(1, 8'h04, 32'h0008_0002);
    bus(1, 8'h08, 32'h0000_0031);
    bus(1, 8'h00, 32'h0000_0001);
    sev <= 4'h1;
    wt(6);
    span();
    `CHK("zone", 4, n)
    sev <= 4'h3;
    wt(6);
    span();
    `CHK("zone", 12, n)
    lst <= rpt_pkg::LS_L1;
    wt(2);
    span();
    `CHK("timer hold", 1'b1, n == 0 || n == 16)
    lst <= rpt_pkg::LS_L0;
    sev <= 4'h0;
    wt(6);
    span();
    `CHK("no severity", 0, n)
    sev <= 4'h2;
    wt(6);
    span();
    `CHK("zone", 12, n)
    bus(1, 8'h00, 32'h0000_0000);
    wt(1);
    span();
    `CHK("disabled", 0, n)
    $display("test throttle done");
    bus(1, 8'h00, 32'h0000_0002);
    foreach (ad[i])
    begin
      r = $urandom();
      if (ad[i] == 16'h008F) lw = r;
      io(1, ad[i], r, ad[i] >= 16'h0080 && ad[i] <= 16'h008F);
    end
    pq.push_back({17'h0, lw});
    io(0, 16'h008F, 0, 1);
    bus(1, 8'h00, 32'h0000_0000);
    io(1, 16'h0080, r, 0);
    wt(3);
    `CHK("io pending", 0, iq.size() + pq.size())
    $display("test diagnostic io done");
    bus(1, 8'h00, 32'h0000_003C);
    pres <= 1'b1;
    wt(5);
    rd(8'h0C, 32'h0000_000F);
    `CHK("irq outs", 3'b111, {intx, sci, smi})
    bus(1, 8'h0C, 32'h0000_001E);
    rd(8'h0C, 32'h0000_0001);
    `CHK("irq outs", 3'b000, {intx, sci, smi})
    @(posedge clk_sys);
    lact <= 1'b1;
    wt(3);
    rd(8'h0C, 32'h0000_0051);
    `CHK("smi", 1'b1, smi)
    bus(1, 8'h0C, 32'h0000_0010);
    pres <= 1'b0;
    wt(5);
    rd(8'h0C, 32'h0000_004E);
    `CHK("intx", 1'b1, intx)
    bus(1, 8'h0C, 32'h0000_001E);
    bus(1, 8'h00, 32'h0000_007C);
    mcnt = 0;
    pres <= 1'b1;
    wt(8);
    `CHK("msi pulses", 1, mcnt)
    `CHK("intx", 1'b0, intx)
    $display("test hotplug done");
    @(posedge clk_sys);
    lst <= rpt_pkg::LS_TRAIN;
    rxinv <= 4'($urandom());
    wt(3);
    `CHK("lane invert", rxinv, linv)
    @(posedge clk_sys);
    lst <= rpt_pkg::LS_DOWN;
    wt(3);
    `CHK("lane invert", 4'h0, linv)
    @(posedge clk_sys);
    sris <= 1'b1;
    reset <= 1'b1;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    wt(6);
    `CHK("sris mode", 4'h4, {l0s, l1x})
    $display("test link modes done");
    final_report();
  end
endmodule
`default_nettype wire
